/* hw/aecc_top.sv */
// The APB register port is this design's own decision.
`timescale 1ns/100ps
// Function
// (R1) injected results are range checked only while injected guard enable is 1
// (R2) regular results are range checked only while regular guard enable is 1
// (R3) writing 1 to converter_on from 0 powers up, then converts
// (R4) writing 1 while converter_on is 1 starts a new conversion directly
// (R5) converter_on 0 stops conversion and calibration, holds power-down
// (R6) a write changing converter_on with other bits starts no conversion
// (R7) repeat select 0 stops after one conversion, 1 restarts automatically
// (R8) calibrate bit set by software, held while running, cleared when done
// (R9) trim_memory_clear bit set by software, cleared when clear completes
// (R10) converter_control_two sits at 0x08 and resets to zero
// (R11) guard_single_channel 0 checks all channels, 1 only the selected one
// (R12) reserved bits read zero and ignore writes
module aecc_top (
    input  wire logic               REF_CLK,
    input  wire logic               NRST,
    input  aecc_pkg::aecc_apb_req_t APB_REQ,
    output aecc_pkg::aecc_apb_rsp_t APB_RSP,
    input  aecc_pkg::aecc_ana_in_t  ANA_IN,
    output aecc_pkg::aecc_ana_out_t ANA_OUT,
    output logic                    IRQ
);
    import aecc_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        aecc_state_t   state;
        logic [31:0]   ctrl1;
        logic [3:0]    ctrl2;
        logic          start_pend;
        logic [11:0]   thr_hi;
        logic [11:0]   thr_lo;
        logic [3:0]    status;
        logic [3:0]    mask;
        logic          irq;
        aecc_ana_out_t ana;
    } aecc_top_st_t;

    localparam aecc_top_st_t RST_ST = '{
        state:      ST_OFF,
        ctrl1:      RST_CTRL1,
        ctrl2:      RST_CTRL2,
        start_pend: 1'b0,
        thr_hi:     RST_THR_HI,
        thr_lo:     RST_THR_LO,
        status:     4'h0,
        mask:       4'h0,
        irq:        1'b0,
        ana:        '0
    };

    aecc_top_st_t q;
    aecc_top_st_t d;
    logic         wr_en;
    logic         mapped;
    logic [31:0]  rd_data;
    logic         t_load;
    logic [15:0]  t_val;
    logic         t_done;
    logic         ctl2_wr;
    logic [3:0]   nw;
    logic         others_chg;
    logic         conv_end;
    logic         guard_en;
    logic         guard_scope;
    logic         hit;
    logic [3:0]   ev;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == OFS_CTRL1) || (a == OFS_CTRL2) ||
                    (a == OFS_THR_HI) || (a == OFS_THR_LO) ||
                    (a == OFS_STATUS) || (a == OFS_MASK);
    endfunction : is_mapped

    function automatic logic outside(input logic [11:0] v,
                                     input logic [11:0] lo,
                                     input logic [11:0] hi);
        outside = (v < lo) || (v > hi);
    endfunction : outside

    // ------------------------------------------------------------
    // bus slave and phase timer
    // ------------------------------------------------------------
    assign mapped = is_mapped(APB_REQ.paddr);

    aecc_apb u_apb (
        .clk     (REF_CLK),
        .nrst    (NRST),
        .req     (APB_REQ),
        .rd_data (rd_data),
        .mapped  (mapped),
        .rsp     (APB_RSP),
        .wr_en   (wr_en)
    );

    aecc_timer #(.W(TMR_W)) u_tmr (
        .clk      (REF_CLK),
        .nrst     (NRST),
        .load     (t_load),
        .load_val (t_val),
        .done     (t_done)
    );

    // reserved positions never stored, so they read as zero
    always_comb begin
        case (APB_REQ.paddr)
            OFS_CTRL1:  rd_data = q.ctrl1;                    // R12
            OFS_CTRL2:  rd_data = {28'h0000000, q.ctrl2};     // R10 R12
            OFS_THR_HI: rd_data = {20'h00000, q.thr_hi};
            OFS_THR_LO: rd_data = {20'h00000, q.thr_lo};
            OFS_STATUS: rd_data = {28'h0000000, q.status};
            OFS_MASK:   rd_data = {28'h0000000, q.mask};
            default:    rd_data = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------
    // guard check
    // ------------------------------------------------------------
    assign conv_end    = (q.state == ST_CONV) && t_done;
    assign guard_en    = ANA_IN.injected ? q.ctrl1[INJ_GD_BIT]   // R1
                                         : q.ctrl1[REG_GD_BIT];  // R2
    assign guard_scope = !q.ctrl1[SGL_BIT] ||                    // R11
        (ANA_IN.channel == q.ctrl1[CH_LSB +: CH_W]);
    assign hit = conv_end && guard_en && guard_scope &&
                 outside(ANA_IN.result, q.thr_lo, q.thr_hi);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    assign ctl2_wr    = wr_en && (APB_REQ.paddr == OFS_CTRL2);
    assign nw         = APB_REQ.pwdata[3:0];
    // only the low nibble exists; upper bits cannot change
    assign others_chg = (nw[3:1] != q.ctrl2[3:1]);

    always_comb begin
        d      = q;
        t_load = 1'b0;
        t_val  = CONV_CYC;
        ev     = 4'h0;
        if (wr_en && APB_REQ.paddr == OFS_CTRL1) begin
            d.ctrl1 = APB_REQ.pwdata & CTRL1_MASK;               // R12
        end
        if (wr_en && APB_REQ.paddr == OFS_THR_HI) begin
            d.thr_hi = APB_REQ.pwdata[11:0];
        end
        if (wr_en && APB_REQ.paddr == OFS_THR_LO) begin
            d.thr_lo = APB_REQ.pwdata[11:0];
        end
        if (wr_en && APB_REQ.paddr == OFS_MASK) begin
            d.mask = APB_REQ.pwdata[3:0];
        end
        if (ctl2_wr) begin
            d.ctrl2[ON_BIT]  = nw[ON_BIT];
            d.ctrl2[REP_BIT] = nw[REP_BIT];                      // R7
            if (nw[CAL_BIT]) begin
                d.ctrl2[CAL_BIT] = 1'b1;                         // R8
            end
            if (nw[CLR_BIT]) begin
                d.ctrl2[CLR_BIT] = 1'b1;                         // R9
            end
            if (nw[ON_BIT] && !others_chg) begin
                d.start_pend = 1'b1;                             // R3 R4 R6
            end
        end
        case (q.state)
            ST_OFF: begin
                if (d.ctrl2[ON_BIT]) begin
                    d.state = ST_PWRUP;                          // R3
                    t_load  = 1'b1;
                    t_val   = PWRUP_CYC;
                end
            end
            ST_PWRUP: begin
                if (t_done) begin
                    d.state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                // clear and calibrate outrank a pending conversion
                if (q.ctrl2[CLR_BIT]) begin
                    d.state = ST_CLR;
                    t_load  = 1'b1;
                    t_val   = CLR_CYC;
                end else if (q.ctrl2[CAL_BIT]) begin
                    d.state = ST_CAL;
                    t_load  = 1'b1;
                    t_val   = CAL_CYC;
                end else if (q.start_pend) begin
                    d.state      = ST_CONV;                      // R4
                    d.start_pend = 1'b0;
                    t_load       = 1'b1;
                end
            end
            ST_CONV: begin
                if (t_done) begin
                    ev[EV_CONV] = 1'b1;
                    if (q.ctrl2[REP_BIT]) begin
                        t_load = 1'b1;                           // R7
                    end else begin
                        d.state = ST_IDLE;                       // R7
                    end
                end
            end
            ST_CAL: begin
                if (t_done) begin
                    // a fresh set in the same cycle wins
                    d.ctrl2[CAL_BIT] = ctl2_wr && nw[CAL_BIT];   // R8
                    ev[EV_CAL]       = 1'b1;
                    d.state          = ST_IDLE;
                end
            end
            ST_CLR: begin
                if (t_done) begin
                    d.ctrl2[CLR_BIT] = ctl2_wr && nw[CLR_BIT];   // R9
                    ev[EV_CLR]       = 1'b1;
                    d.state          = ST_IDLE;
                end
            end
            default: begin
                d.state = ST_OFF;
            end
        endcase
        // power-down aborts everything, including pending requests
        if (!d.ctrl2[ON_BIT]) begin
            d.state          = ST_OFF;                           // R5
            d.ctrl2[CAL_BIT] = 1'b0;                             // R5
            d.ctrl2[CLR_BIT] = 1'b0;
            d.start_pend     = 1'b0;
        end
        ev[EV_GUARD] = hit;
        // set wins over write-one-to-clear
        if (wr_en && APB_REQ.paddr == OFS_STATUS) begin
            d.status = q.status & ~APB_REQ.pwdata[3:0];
        end
        d.status         = d.status | ev;
        d.irq            = |(d.status & d.mask);
        d.ana.power      = (d.state != ST_OFF);                  // R5
        d.ana.sample     = (d.state == ST_CONV);
        d.ana.calibrate  = (d.state == ST_CAL);
        d.ana.trim_clear = (d.state == ST_CLR);
        d.ana.guard_hit  = hit;
    end

    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            q <= RST_ST;                                         // R10
        end else begin
            q <= d;
        end
    end

    assign ANA_OUT = q.ana;
    assign IRQ     = q.irq;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    localparam int PU_DLY = 11;

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!NRST);

    inj_guard_off_a: assert property ( // R1
        conv_end && ANA_IN.injected && !q.ctrl1[INJ_GD_BIT]
        |=> !ANA_OUT.guard_hit)
        else $error("injected result checked while disabled");

    reg_guard_off_a: assert property ( // R2
        conv_end && !ANA_IN.injected && !q.ctrl1[REG_GD_BIT]
        |=> !ANA_OUT.guard_hit)
        else $error("regular result checked while disabled");

    power_up_a: assert property ( // R3
        q.state == ST_OFF && ctl2_wr && nw[ON_BIT] && !others_chg
        |=> ANA_OUT.power ##[PU_DLY:PU_DLY] q.state == ST_CONV)
        else $error("power-up did not lead to a conversion");

    restart_a: assert property ( // R4
        q.state == ST_IDLE && q.ctrl2[ON_BIT] && ctl2_wr &&
        nw[ON_BIT] && !others_chg && nw[CLR_BIT:CAL_BIT] == 2'b00
        |-> ##2 q.state == ST_CONV)
        else $error("restart write did not convert");

    off_hold_a: assert property ( // R5
        !q.ctrl2[ON_BIT] |-> q.state == ST_OFF && !ANA_OUT.power &&
        !q.ctrl2[CAL_BIT] && !ANA_OUT.sample)
        else $error("activity while converter is off");

    mixed_write_a: assert property ( // R6
        ctl2_wr && others_chg && !q.start_pend |=> !q.start_pend)
        else $error("mixed write queued a conversion");

    single_stop_a: assert property ( // R7
        conv_end && !q.ctrl2[REP_BIT] && !(ctl2_wr && !nw[ON_BIT])
        |=> q.state == ST_IDLE)
        else $error("single mode did not stop");

    repeat_conv_a: assert property ( // R7
        conv_end && q.ctrl2[REP_BIT] && !(ctl2_wr && !nw[ON_BIT])
        // reload checked at once: a later power-off may cut the run short
        |=> q.state == ST_CONV && ANA_OUT.sample && !t_done)
        else $error("continuous mode did not restart");

    cal_done_a: assert property ( // R8
        q.state == ST_CAL && t_done && !(ctl2_wr && nw[CAL_BIT])
        |=> !q.ctrl2[CAL_BIT] && q.status[EV_CAL])
        else $error("calibrate bit not cleared at end");

    cal_hold_a: assert property ( // R8
        q.state == ST_CAL && !t_done && !(ctl2_wr && !nw[ON_BIT])
        |=> q.ctrl2[CAL_BIT])
        else $error("calibrate bit dropped while running");

    clr_done_a: assert property ( // R9
        q.state == ST_CLR && t_done && !(ctl2_wr && nw[CLR_BIT])
        |=> !q.ctrl2[CLR_BIT] && q.status[EV_CLR])
        else $error("clear bit not cleared at end");

    reset_val_a: assert property (disable iff (1'b0) // R10
        !NRST |=> q.ctrl2 == RST_CTRL2 && q.state == ST_OFF)
        else $error("control register not zero after reset");

    scope_a: assert property ( // R11
        conv_end && q.ctrl1[SGL_BIT] &&
        ANA_IN.channel != q.ctrl1[CH_LSB +: CH_W] |=> !ANA_OUT.guard_hit)
        else $error("unselected channel was checked");

    rsvd_read_a: assert property ( // R12
        APB_REQ.psel && APB_REQ.penable && !APB_REQ.pwrite &&
        APB_REQ.paddr == OFS_CTRL2 |-> APB_RSP.prdata[31:4] == 28'h0)
        else $error("reserved bits read nonzero");

    conv_c:   cover property (conv_end ##1 q.state == ST_IDLE);
    repeat_c: cover property (conv_end && q.ctrl2[REP_BIT]);
    cal_c:    cover property (q.state == ST_CAL && t_done);
    clr_c:    cover property (q.state == ST_CLR && t_done);
    guard_c:  cover property (hit ##1 IRQ);

endmodule : aecc_top

/* include/aecc_pkg.sv */
package aecc_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0]  OFS_CTRL1   = 8'h04;
    localparam logic [7:0]  OFS_CTRL2   = 8'h08;
    localparam logic [7:0]  OFS_THR_HI  = 8'h24;
    localparam logic [7:0]  OFS_THR_LO  = 8'h28;
    localparam logic [7:0]  OFS_STATUS  = 8'h30;
    localparam logic [7:0]  OFS_MASK    = 8'h34;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int          CH_LSB      = 0;
    localparam int          CH_W        = 5;
    localparam int          SCAN_BIT    = 8;
    localparam int          SGL_BIT     = 9;
    localparam int          INJ_GD_BIT  = 22;
    localparam int          REG_GD_BIT  = 23;
    localparam int          ON_BIT      = 0;
    localparam int          REP_BIT     = 1;
    localparam int          CAL_BIT     = 2;
    localparam int          CLR_BIT     = 3;
    localparam int          EV_CONV     = 0;
    localparam int          EV_GUARD    = 1;
    localparam int          EV_CAL      = 2;
    localparam int          EV_CLR      = 3;
    localparam int          EV_W        = 4;
    localparam int          RES_W       = 12;

    // ------------------------------------------------------------
    // writable masks and reset values
    // ------------------------------------------------------------
    localparam logic [31:0] CTRL1_MASK  = 32'h00c0_031f;
    localparam logic [31:0] RST_CTRL1   = 32'h0000_0000;
    localparam logic [3:0]  RST_CTRL2   = 4'h0;
    localparam logic [11:0] RST_THR_HI  = 12'hfff;
    localparam logic [11:0] RST_THR_LO  = 12'h000;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int          CLK_NS      = 100;
    localparam int          T_PWRUP_NS  = 1000;
    localparam int          T_CONV_NS   = 1400;
    localparam int          T_CAL_NS    = 8300;
    localparam int          T_CLR_NS    = 200;
    localparam int          TMR_W       = 16;
    localparam logic [15:0] PWRUP_CYC   =
        16'((T_PWRUP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] CONV_CYC    =
        16'((T_CONV_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] CAL_CYC     =
        16'((T_CAL_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] CLR_CYC     =
        16'((T_CLR_NS + CLK_NS - 1) / CLK_NS);

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_OFF   = 6'h01,
        ST_PWRUP = 6'h02,
        ST_IDLE  = 6'h04,
        ST_CONV  = 6'h08,
        ST_CAL   = 6'h10,
        ST_CLR   = 6'h20
    } aecc_state_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } aecc_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } aecc_apb_rsp_t;

    typedef struct packed {
        logic [11:0] result;
        logic [4:0]  channel;
        logic        injected;
    } aecc_ana_in_t;

    typedef struct packed {
        logic power;
        logic sample;
        logic calibrate;
        logic trim_clear;
        logic guard_hit;
    } aecc_ana_out_t;

endpackage : aecc_pkg

/* hw/aecc_timer.sv */
`timescale 1ns/100ps
module aecc_timer #(
    parameter int W = 16
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    output logic              done
);
    import aecc_pkg::*;

    typedef struct packed {
        logic [W-1:0] cnt;
    } aecc_tmr_st_t;

    aecc_tmr_st_t q;
    aecc_tmr_st_t d;

    // phase lasts load_val cycles; done flags its last one
    always_comb begin
        d = q;
        if (load) begin
            d.cnt = load_val;
        end else if (q.cnt != '0) begin
            d.cnt = q.cnt - W'(1);
        end
    end

    assign done = (q.cnt == W'(1));

    always_ff @(posedge clk) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule : aecc_timer

/* hw/aecc_apb.sv */
`timescale 1ns/100ps
module aecc_apb (
    input  wire logic            clk,
    input  wire logic            nrst,
    input  aecc_pkg::aecc_apb_req_t req,
    input  wire logic [31:0]     rd_data,
    input  wire logic            mapped,
    output aecc_pkg::aecc_apb_rsp_t rsp,
    output logic                 wr_en
);
    import aecc_pkg::*;

    typedef struct packed {
        logic [31:0] prdata;
    } aecc_apb_st_t;

    aecc_apb_st_t q;
    aecc_apb_st_t d;
    logic         access;

    // read data is snapshot in setup so it is steady in access
    always_comb begin
        d = q;
        if (req.psel && !req.penable && !req.pwrite) begin
            d.prdata = mapped ? rd_data : 32'h0000_0000;
        end
    end

    // zero wait states: every access completes in one cycle
    assign access      = req.psel && req.penable;
    assign wr_en       = access && req.pwrite && mapped;
    assign rsp.prdata  = q.prdata;
    assign rsp.pready  = 1'b1;
    assign rsp.pslverr = access && !mapped;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule : aecc_apb

/* tb/test_adc_enable_calibration_control.sv */
`timescale 1ns/100ps
`define CHK(n, e, g) begin \
    compares++; \
    if ((g) !== (e)) begin \
        mismatches++; \
        $display("[FAIL] %s exp %h got %h", n, e, g); \
    end \
end
module test_adc_enable_calibration_control;
    import aecc_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic          ref_clk    = 1'b0;
    logic          nrst       = 1'b0;
    aecc_apb_req_t req        = '0;
    aecc_apb_rsp_t rsp;
    aecc_ana_in_t  ana_in     = '0;
    aecc_ana_out_t ana_out;
    logic          irq;
    int            mismatches = 0;
    int            compares   = 0;
    int            cycles     = 0;
    int            hits       = 0;
    logic [31:0]   rd;
    logic          err;
    logic          got;

    aecc_top dut_u (
        .REF_CLK (ref_clk),
        .NRST    (nrst),
        .APB_REQ (req),
        .APB_RSP (rsp),
        .ANA_IN  (ana_in),
        .ANA_OUT (ana_out),
        .IRQ     (irq)
    );

    always #50 ref_clk = ~ref_clk;

    // guard pulses last one cycle, so count them at every edge
    always @(posedge ref_clk) begin
        cycles++;
        if (ana_out.guard_hit === 1'b1)
            hits++;
        if (cycles == 20000) begin
            mismatches++;
            complete_run();
        end
    end

    // ------------------------------------------------------------
    // bus and wait helpers
    // ------------------------------------------------------------
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge ref_clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a,
                 pwdata: wd};
        @(posedge ref_clk);
        req.penable <= 1'b1;
        do @(posedge ref_clk); while (rsp.pready !== 1'b1);
        rd  = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
    endtask : apb

    // s 0 watches sample, 1 calibrate, 2 trim_clear; bounded wait
    task automatic wait_on(input int s, input logic l, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk);
            got = (s == 2) ? ana_out.trim_clear :
                  (s == 1) ? ana_out.calibrate : ana_out.sample;
            if (got === l)
                break;
        end
    endtask : wait_on

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        apb(0, OFS_CTRL2, 0);
        `CHK("ctrl2 reset", 32'h0000_0000, rd)
        apb(0, 8'h40, 0);
        `CHK("unmapped err", 1'b1, err)
        apb(1, OFS_CTRL2, 32'hffff_fff0);
        apb(0, OFS_CTRL2, 0);
        `CHK("reserved bits", 32'h0000_0000, rd)
        $display("test regs done");
    endtask : t_regs

    task automatic t_power;
        apb(1, OFS_MASK, 32'h0000_0001);
        apb(1, OFS_CTRL2, 32'h0000_0001);
        repeat (3) @(posedge ref_clk);
        `CHK("power up", 1'b1, ana_out.power)
        `CHK("no early sample", 1'b0, ana_out.sample)
        wait_on(0, 1'b1, 20);
        `CHK("first conv", 1'b1, got)
        wait_on(0, 1'b0, 20);
        repeat (4) @(posedge ref_clk);
        `CHK("single stops", 1'b0, ana_out.sample)
        `CHK("irq set", 1'b1, irq)
        apb(1, OFS_STATUS, 32'h0000_0001);
        repeat (2) @(posedge ref_clk);
        `CHK("irq cleared", 1'b0, irq)
        $display("test power done");
    endtask : t_power

    task automatic t_restart;
        // no power-up step, so sample comes within a few cycles
        apb(1, OFS_CTRL2, 32'h0000_0001);
        wait_on(0, 1'b1, 4);
        `CHK("restart", 1'b1, got)
        wait_on(0, 1'b0, 20);
        $display("test restart done");
    endtask : t_restart

    task automatic t_guard;
        logic [31:0] c1 [6] = '{32'h0080_0000, 32'h0080_0000,
            32'h0040_0000, 32'h0040_0000, 32'h0080_0203, 32'h0080_0205};
        logic        inj [6] = '{0, 1, 1, 0, 0, 0};
        int          ex  [6] = '{1, 0, 1, 0, 0, 1};
        int          h0;
        apb(1, OFS_THR_HI, 32'h0000_0100);
        for (int i = 0; i < 6; i++) begin
            apb(1, OFS_CTRL1, c1[i]);
            ana_in <= '{result: 12'h200, channel: 5'h05,
                        injected: inj[i]};
            h0 = hits;
            apb(1, OFS_CTRL2, 32'h0000_0001);
            wait_on(0, 1'b1, 6);
            wait_on(0, 1'b0, 20);
            repeat (3) @(posedge ref_clk);
            `CHK("guard hit", ex[i], hits - h0)
        end
        $display("test guard done");
    endtask : t_guard

    task automatic t_repeat;
        apb(1, OFS_CTRL2, 32'h0000_0003);
        apb(1, OFS_CTRL2, 32'h0000_0003);
        wait_on(0, 1'b1, 6);
        `CHK("cont start", 1'b1, got)
        wait_on(0, 1'b0, 20);
        wait_on(0, 1'b1, 4);
        `CHK("auto restart", 1'b1, got)
        apb(1, OFS_CTRL2, 32'h0000_0000);
        repeat (3) @(posedge ref_clk);
        `CHK("off sample", 1'b0, ana_out.sample)
        `CHK("off power", 1'b0, ana_out.power)
        // on together with repeat select: must not convert
        apb(1, OFS_CTRL2, 32'h0000_0003);
        wait_on(0, 1'b1, 30);
        `CHK("mixed write", 1'b0, got)
        apb(1, OFS_CTRL2, 32'h0000_0000);
        $display("test repeat done");
    endtask : t_repeat

    task automatic t_cal;
        apb(1, OFS_CTRL2, 32'h0000_0001);
        wait_on(0, 1'b1, 20);
        wait_on(0, 1'b0, 20);
        apb(1, OFS_CTRL2, 32'h0000_0005);
        apb(0, OFS_CTRL2, 0);
        `CHK("cal bit held", 1'b1, rd[2])
        wait_on(1, 1'b1, 4);
        `CHK("cal runs", 1'b1, got)
        wait_on(1, 1'b0, 100);
        `CHK("cal ends", 1'b0, got)
        apb(0, OFS_CTRL2, 0);
        `CHK("cal cleared", 32'h0000_0001, rd)
        apb(1, OFS_CTRL2, 32'h0000_0009);
        wait_on(2, 1'b1, 4);
        `CHK("clear runs", 1'b1, got)
        repeat (10) @(posedge ref_clk);
        `CHK("clear ends", 1'b0, ana_out.trim_clear)
        apb(0, OFS_CTRL2, 0);
        `CHK("clear bit", 32'h0000_0001, rd)
        apb(0, OFS_STATUS, 0);
        `CHK("done flags", 2'b11, rd[3:2])
        // power-down in mid calibration aborts it
        apb(1, OFS_CTRL2, 32'h0000_0005);
        wait_on(1, 1'b1, 4);
        apb(1, OFS_CTRL2, 32'h0000_0000);
        repeat (2) @(posedge ref_clk);
        `CHK("abort cal", 1'b0, ana_out.calibrate)
        `CHK("abort power", 1'b0, ana_out.power)
        apb(0, OFS_CTRL2, 0);
        `CHK("abort bits", 32'h0000_0000, rd)
        $display("test cal done");
    endtask : t_cal

    task automatic complete_run;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge ref_clk);
        nrst <= 1'b1;
        t_regs();
        t_power();
        t_restart();
        t_guard();
        t_repeat();
        t_cal();
        complete_run();
    end
endmodule : test_adc_enable_calibration_control
